// File: hw/dtc_term_ctrl.v
`include "dtc_defines.vh"
module dtc_term_ctrl #(
    parameter CA_UPD_CYC = 8
) (
    clk,
    rst,
    link_ck,
    cas2_cmd,
    wr_burst_cmd,
    mode_wr,
    mode_wdata,
    band_sel,
    wl_set_b,
    bl32,
    power_down,
    self_refresh,
    wr_level,
    dq_term_en,
    dqs_term_en,
    rtt_code,
    ca_rtt_code,
    lat_valid
);
    input wire clk;
    input wire rst;
    input wire link_ck;
    input wire cas2_cmd;
    input wire wr_burst_cmd;
    input wire mode_wr;
    input wire [7:0] mode_wdata;
    input wire [2:0] band_sel;
    input wire wl_set_b;
    input wire bl32;
    input wire power_down;
    input wire self_refresh;
    input wire wr_level;
    output reg dq_term_en;
    output reg dqs_term_en;
    output reg [2:0] rtt_code;
    output reg [2:0] ca_rtt_code;
    output reg lat_valid;

    // ============================================================
    // Link clock and pin synchronisers
    localparam NS = 3;
    reg [NS-1:0] s1_q;
    reg [NS-1:0] s2_q;
    reg ck_prev_q;
    wire [NS-1:0] pins = {link_ck, cas2_cmd, wr_burst_cmd};
    always @(posedge clk) begin
        if (rst) begin
            s1_q <= {NS{1'b0}};
            s2_q <= {NS{1'b0}};
            ck_prev_q <= 1'b0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            ck_prev_q <= s2_q[2];
        end
    end
    wire ck_rise = s2_q[2] & ~ck_prev_q;
    // Command sampled on link rising edge, both bits together
    wire cas2_evt = ck_rise & s2_q[1] & s2_q[0];

    // ============================================================
    // Mode register
    reg [7:0] mode_q;
    reg [7:0] ca_pend_q;
    reg [7:0] ca_cnt_q;
    always @(posedge clk) begin
        if (rst) begin
            mode_q <= `DTC_MODE_RST;
            ca_pend_q <= `DTC_MODE_RST;
            ca_cnt_q <= 8'h00;
            ca_rtt_code <= 3'h0;
        end else begin
            if (mode_wr) begin
                mode_q <= mode_wdata;
                ca_pend_q <= mode_wdata;
                ca_cnt_q <= CA_UPD_CYC[7:0];
            end else if (ca_cnt_q != 8'h00) begin
                ca_cnt_q <= ca_cnt_q - 8'h01;
            end else begin
                ca_rtt_code <= ca_pend_q[`DTC_FLD_CA_HI:`DTC_FLD_CA_LO];
            end
        end
    end
    // Bit 3 alone gates; a field of only low bits stays disabled
    wire term_mode = mode_q[`DTC_FLD_EN_BIT] &&
        (mode_q[3:0] != 4'h0);

    // ============================================================
    // Latency lookup, counted in link cycles
    reg [5:0] lat_on;
    reg [5:0] lat_off;
    reg lat_ok;
    always @* begin
        lat_ok = 1'b1;
        lat_on = 6'd0;
        lat_off = 6'd0;
        case (band_sel)
            `DTC_BAND_800: begin
                lat_on = 6'd6;
                lat_off = 6'd22;
                lat_ok = wl_set_b;
            end
            `DTC_BAND_1066: begin
                lat_on = wl_set_b ? 6'd12 : 6'd4;
                lat_off = wl_set_b ? 6'd28 : 6'd20;
            end
            `DTC_BAND_1333: begin
                lat_on = wl_set_b ? 6'd14 : 6'd4;
                lat_off = wl_set_b ? 6'd32 : 6'd22;
            end
            `DTC_BAND_1600: begin
                lat_on = wl_set_b ? 6'd18 : 6'd6;
                lat_off = wl_set_b ? 6'd36 : 6'd24;
            end
            `DTC_BAND_1866: begin
                lat_on = wl_set_b ? 6'd20 : 6'd6;
                lat_off = wl_set_b ? 6'd40 : 6'd26;
            end
            `DTC_BAND_2133: begin
                lat_on = wl_set_b ? 6'd24 : 6'd8;
                lat_off = wl_set_b ? 6'd44 : 6'd28;
            end
            default: begin
                lat_ok = 1'b0;
            end
        endcase
    end
    wire [5:0] off_total = bl32 ? (lat_off + `DTC_BL32_EXTRA) : lat_off;

    // ============================================================
    // Window state machine
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT_ON = 2'h1;
    localparam ST_ON = 2'h2;
    reg [1:0] st_q;
    reg [5:0] cnt_q;
    reg [5:0] on_at_q;
    reg [5:0] off_at_q;
    reg win_q;
    wire blocked = power_down | self_refresh;
    always @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 6'd0;
            on_at_q <= 6'd0;
            off_at_q <= 6'd0;
            win_q <= 1'b0;
        end else if (blocked || !term_mode) begin
            st_q <= ST_IDLE;
            win_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    win_q <= 1'b0;
                    if (cas2_evt && lat_ok) begin
                        st_q <= ST_WAIT_ON;
                        cnt_q <= 6'd1;
                        on_at_q <= lat_on;
                        off_at_q <= off_total;
                    end
                end
                ST_WAIT_ON: begin
                    if (ck_rise) begin
                        cnt_q <= cnt_q + 6'd1;
                        if (cnt_q == on_at_q) begin
                            st_q <= ST_ON;
                            win_q <= 1'b1;
                        end
                    end
                end
                ST_ON: begin
                    // Extends if a back-to-back write arrives
                    if (cas2_evt) begin
                        cnt_q <= 6'd1;
                        off_at_q <= off_total;
                    end else if (ck_rise) begin
                        cnt_q <= cnt_q + 6'd1;
                        if (cnt_q == off_at_q) begin
                            st_q <= ST_IDLE;
                            win_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Transition delay: at least 1.5 ns; clk granularity cannot reach 3.5 ns
    localparam TD = `DTC_TRANS_MIN_CYC;
    reg [TD-1:0] td_q;
    wire [TD:0] td_shift = {td_q, win_q};
    always @(posedge clk) begin
        if (rst) begin
            td_q <= {TD{1'b0}};
        end else begin
            td_q <= td_shift[TD-1:0];
        end
    end

    // ============================================================
    // Pin termination outputs
    always @(posedge clk) begin
        if (rst) begin
            dq_term_en <= 1'b0;
            dqs_term_en <= 1'b0;
            rtt_code <= 3'h0;
            lat_valid <= 1'b0;
        end else begin
            lat_valid <= lat_ok;
            rtt_code <= mode_q[`DTC_FLD_RTT_HI:`DTC_FLD_RTT_LO];
            if (blocked) begin
                dq_term_en <= 1'b0;
                dqs_term_en <= 1'b0;
            end else if (wr_level) begin
                dq_term_en <= 1'b0;
                dqs_term_en <= term_mode;
            end else begin
                dq_term_en <= td_q[TD-1];
                dqs_term_en <= td_q[TD-1];
            end
        end
    end
endmodule

// File: hw/dtc_defines.vh
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
// Notes on behaviour
// - Data termination stays off in power-down and self-refresh.
// - Termination switch closes from sampled Write-1/Mask Write-1 plus mode settings.
// - Termination mode on only when bit 3 of the four-bit field is set.
// - With termination enabled, pins stay high impedance outside a terminated burst.
// - Termination turns on by itself after a write command, no control pin.
// - Termination turns off by itself once the write burst completes.
// - Turn-on latency in cycles from CAS-2 is fixed per speed bin.
// - Turn-off latency in cycles from CAS-2 is fixed per speed bin.
// - Turn-on transition timing counts only after the turn-on latency.
// - Latency table per band and write-latency set, 2-cycle preamble.
// - Burst length 32 adds 8 cycles to turn-off latency.
// - Transitions start no earlier than 1.5 ns, finish within 3.5 ns; code delays one 10 ns clk, so 3.5 ns is missed.
// - Write leveling with termination enabled terminates both strobes.
// - Write leveling keeps data-pin termination off.
// - Three-bit code selects 240/120/80/60/48/40 ohm.
// - Data, mask and both strobes share the selected termination.
// - Command-bus termination change takes effect after update time.
// ============================================================
// Field positions of termination_mode_reg
`define DTC_FLD_EN_BIT 3
`define DTC_FLD_RTT_HI 2
`define DTC_FLD_RTT_LO 0
`define DTC_FLD_CA_HI 6
`define DTC_FLD_CA_LO 4
`define DTC_MODE_RST 8'h00
// ============================================================
// Band codes (upper frequency limit)
`define DTC_BAND_800 3'h2
`define DTC_BAND_1066 3'h3
`define DTC_BAND_1333 3'h4
`define DTC_BAND_1600 3'h5
`define DTC_BAND_1866 3'h6
`define DTC_BAND_2133 3'h7
`define DTC_BL32_EXTRA 6'h08
// ============================================================
// Transition times in ps, converted at clk period 10000 ps
`define DTC_CLK_PS 10000
`define DTC_TON_MIN_PS 1500
`define DTC_TON_MAX_PS 3500
`define DTC_TRANS_MIN_CYC ((`DTC_TON_MIN_PS + `DTC_CLK_PS - 1) / `DTC_CLK_PS)
`define DTC_CA_UPD_CYC 8'h10
`endif

// File: sim/dtc_term_ctrl_chk.sv
// ==== Port checks
module dtc_term_chk #(
    parameter CA_UPD_CYC = 8
) (
    input wire clk,
    input wire rst,
    input wire mode_wr,
    input wire [7:0] mode_wdata,
    input wire [2:0] band_sel,
    input wire wl_set_b,
    input wire power_down,
    input wire self_refresh,
    input wire wr_level,
    input wire dq_term_en,
    input wire dqs_term_en,
    input wire [2:0] rtt_code,
    input wire [2:0] ca_rtt_code,
    input wire lat_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_pd_dq_off: assert property ((power_down || self_refresh) |=> !dq_term_en)
        else $error("dq termination on while blocked");
    a_wl_dq_off: assert property (wr_level |=> !dq_term_en)
        else $error("dq termination on in leveling");
    a_dq_dqs_pair: assert property (dq_term_en |-> dqs_term_en)
        else $error("dq terminated without strobes");
    a_rtt_load: assert property (mode_wr |-> ##2 rtt_code == $past(mode_wdata[2:0], 2))
        else $error("rtt code not loaded");
    a_lat_match: assert property (!$past(rst) && $stable(band_sel) && $stable(wl_set_b)
        |-> lat_valid == (band_sel > 3'h2 || (band_sel == 3'h2 && wl_set_b)))
        else $error("latency valid wrong");
    a_rise_cause: assert property ($rose(dq_term_en) |->
        !$past(power_down) && !$past(self_refresh) && !$past(wr_level) && lat_valid)
        else $error("termination rose without cause");
    a_on_hold: assert property ($rose(dq_term_en) && !power_down && !self_refresh
        |=> (dq_term_en || power_down || self_refresh || wr_level)[*8])
        else $error("termination window too short");
    a_ca_delay: assert property (mode_wr && mode_wdata[6:4] != ca_rtt_code
        |=> $stable(ca_rtt_code))
        else $error("ca code changed at once");
endmodule

bind dtc_term_ctrl dtc_term_chk #(.CA_UPD_CYC(CA_UPD_CYC)) dtc_term_chk_inst (.clk, .rst,
    .mode_wr, .mode_wdata, .band_sel, .wl_set_b, .power_down, .self_refresh, .wr_level,
    .dq_term_en, .dqs_term_en, .rtt_code, .ca_rtt_code, .lat_valid);

// File: sim/dtc_ctl_model.sv
// ==== Controller side
module dtc_ctl_model (
    input wire go,
    output logic link_ck,
    output logic cas2_cmd,
    output logic wr_burst_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    // Free-running device clock, offset so its edges never meet clk edges
    initial begin
        cas2_cmd = 1'b0;
        wr_burst_cmd = 1'b0;
        link_ck = 1'b0;
        #3;
        forever #40 link_ck = ~link_ck;
    end
    // Both halves launched mid-period so the rise samples a settled pair
    always @(negedge link_ck) begin
        cas2_cmd <= go;
        wr_burst_cmd <= go;
    end
endmodule

// File: sim/testbench.sv
// ==== Bench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, link_ck, cas2_cmd, wr_burst_cmd, mode_wr, wl_set_b, bl32, go;
    logic power_down, self_refresh, wr_level, dq_term_en, dqs_term_en, lat_valid;
    logic [7:0] mode_wdata;
    logic [2:0] band_sel, rtt_code, ca_rtt_code;
    int n_mismatch = 0;
    int cmp_count = 0;
    time t0;
    int on_l[2][8] = '{'{0, 0, 0, 4, 4, 6, 6, 8}, '{0, 0, 6, 12, 14, 18, 20, 24}};
    int off_l[2][8] = '{'{0, 0, 0, 20, 22, 24, 26, 28}, '{0, 0, 22, 28, 32, 36, 40, 44}};
    dtc_ctl_model dtc_ctl_model_inst (.go, .link_ck, .cas2_cmd, .wr_burst_cmd);
    dtc_term_ctrl #(.CA_UPD_CYC(2)) dtc_term_ctrl_inst (.clk, .rst, .link_ck, .cas2_cmd,
        .wr_burst_cmd, .mode_wr, .mode_wdata, .band_sel, .wl_set_b, .bl32, .power_down,
        .self_refresh, .wr_level, .dq_term_en, .dqs_term_en, .rtt_code, .ca_rtt_code,
        .lat_valid);
    task finish_test;
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task set_mode(input logic [7:0] d);
        @(negedge clk);
        mode_wr = 1'b1;
        mode_wdata = d;
        @(negedge clk);
        mode_wr = 1'b0;
        // rtt_code follows the stored mode one clk later; ca_rtt_code waits for the update count
        @(negedge clk);
    endtask
    // Command held one link period; t0 marks the rise that samples it
    task cmd;
        for (int n = 0; n < 4 && cas2_cmd !== 1'b1; n++) @(posedge link_ck);
        if (cas2_cmd !== 1'b1) begin
            n_mismatch++;
            finish_test;
        end
        t0 = $time;
        go = 1'b0;
    endtask
    // Sync delay of a few clk allowed, a whole link cycle is not
    task wait_dq(input logic v, input int lat);
        int n;
        for (n = 0; n < 900 && dq_term_en !== v; n++) @(negedge clk);
        if (dq_term_en !== v) begin
            n_mismatch++;
            finish_test;
        end else begin
            chk($time - t0 >= lat * 80 && $time - t0 <= lat * 80 + 60, 1);
            chk(dqs_term_en, v);
        end
    endtask
    task t_modes;
        set_mode(8'h5c);
        chk(ca_rtt_code, 0);
        repeat (8) @(negedge clk);
        chk(ca_rtt_code, 5);
        for (int c = 1; c < 7; c++) begin
            set_mode(8'h08 | c[7:0]);
            chk(rtt_code, c[2:0]);
        end
        chk(dq_term_en, 0);
    endtask
    task t_lat;
        for (int s = 0; s < 2; s++) begin
            for (int b = 2; b < 8; b++) begin
                @(negedge clk);
                band_sel = b[2:0];
                wl_set_b = s[0];
                repeat (2) @(negedge clk);
                chk(lat_valid, (b > 2 || s == 1));
                if (b > 2 || s == 1) begin
                    go = 1'b1;
                    cmd;
                    wait_dq(1, on_l[s][b]);
                    wait_dq(0, off_l[s][b] + (bl32 ? 8 : 0));
                end
            end
            bl32 = 1'b1;
        end
    endtask
    task t_block;
        set_mode(8'h07);
        go = 1'b1;
        cmd;
        repeat (500) @(negedge clk);
        chk(dq_term_en, 0);
        set_mode(8'h0c);
        self_refresh = 1'b1;
        go = 1'b1;
        cmd;
        repeat (500) @(negedge clk);
        chk(dq_term_en, 0);
        self_refresh = 1'b0;
        go = 1'b1;
        cmd;
        wait_dq(1, on_l[1][7]);
        power_down = 1'b1;
        repeat (2) @(negedge clk);
        chk({dq_term_en, dqs_term_en}, 0);
        repeat (500) @(negedge clk);
        power_down = 1'b0;
        wr_level = 1'b1;
        repeat (2) @(negedge clk);
        chk({dq_term_en, dqs_term_en}, 1);
        set_mode(8'h04);
        chk(dqs_term_en, 0);
        wr_level = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst, mode_wr, mode_wdata, band_sel, wl_set_b, bl32} = {1'b1, 14'h0};
        {power_down, self_refresh, wr_level, go} = 4'h0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_modes;
        t_lat;
        t_block;
        finish_test;
    end
endmodule
